//--- spcbp_pkg.sv
// spcbp_pkg: constants, register map and types for the spindle commutation block
// assumes a 10 MHz core clock; all times are converted to cycles here
package spcbp_pkg;

  // core clock
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;

  // register bus
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;
  localparam logic [ADDR_W-1:0] REG_CTRL    = 4'h0;
  localparam logic [ADDR_W-1:0] REG_PRELOAD = 4'h4;
  localparam logic [ADDR_W-1:0] REG_DUTY    = 4'h8;
  localparam logic [ADDR_W-1:0] REG_STATUS  = 4'hC;

  // control fields
  localparam int unsigned CTRL_START_BIT = 0;
  localparam logic        CTRL_START_RST = 1'b1;

  // status fields
  localparam int unsigned ST_PHDET_BIT  = 0;
  localparam int unsigned ST_SEQEN_BIT  = 1;
  localparam int unsigned ST_STATE_LSB  = 2;
  localparam int unsigned ST_BEMF_BIT   = 5;
  localparam int unsigned ST_TRIPOL_BIT = 6;
  localparam int unsigned ST_SIDE_BIT   = 7;

  // drive pattern: {a_hi, a_lo, b_hi, b_lo, c_hi, c_lo}
  localparam int unsigned PAT_W = 6;
  localparam logic [PAT_W-1:0] PAT_ALL_ONES = 6'h3F;
  localparam logic [PAT_W-1:0] PAT_RST      = 6'h00;

  // chop timing
  localparam int unsigned CHOP_FREQ_HZ   = 22_000;
  localparam int unsigned CHOP_CYC       = CLK_HZ / CHOP_FREQ_HZ;
  localparam int unsigned MIN_OFF_NS     = 2000;
  localparam int unsigned MIN_OFF_CYC    = (MIN_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned EDGE_NS        = 1500;
  localparam int unsigned EDGE_CYC       = (EDGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ON_DEL_PCT     = 22;
  localparam int unsigned RAMP_CYC       = CHOP_CYC - MIN_OFF_CYC;
  localparam int unsigned ON_DEL_CYC     = RAMP_CYC * ON_DEL_PCT / 100;
  localparam int unsigned BLANK_NS       = 25000;
  localparam int unsigned BLANK_CYC      = BLANK_NS / CLK_PERIOD_NS;
  localparam int unsigned CNT_W          = 9;
  localparam logic [CNT_W-1:0] DUTY_RST  = 9'h000;

  // commutation states, gray coded from S0 to S5; the S5 to S0 wrap changes all three bits
  typedef enum logic [2:0] {
    SPCBP_S0 = 3'h0,
    SPCBP_S1 = 3'h1,
    SPCBP_S2 = 3'h3,
    SPCBP_S3 = 3'h2,
    SPCBP_S4 = 3'h6,
    SPCBP_S5 = 3'h7
  } spcbp_state_t;

endpackage

//--- spcbp_chop_if.sv
// spcbp_chop_if: carries chop timing between the top and the chop timer
// assumes both ends run on the same core clock
`timescale 1ns/1ns
interface spcbp_chop_if;
  import spcbp_pkg::*;
  logic             sync_p;
  logic [CNT_W-1:0] duty;
  logic             chop_on;
  logic             on_del_win;
  logic             blank;
  modport timer (input sync_p, input duty, output chop_on, output on_del_win, output blank);
  modport user  (output sync_p, output duty, input chop_on, input on_del_win, input blank);
endinterface

//--- spcbp_chop.sv
// spcbp_chop: chop period timer with minimum off one-shot, on-delay window, blank pulse
// assumes sync_p is a one-cycle pulse on each commutation clock rising edge
`timescale 1ns/1ns
module spcbp_chop
  import spcbp_pkg::*;
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  // timing link
  spcbp_chop_if.timer cif
);

  localparam logic [CNT_W-1:0] PER_M1  = CNT_W'(CHOP_CYC - 1);
  localparam logic [CNT_W-1:0] MAX_ON  = CNT_W'(CHOP_CYC - MIN_OFF_CYC);
  localparam logic [CNT_W-1:0] WIN_LEN = CNT_W'(ON_DEL_CYC);
  localparam logic [CNT_W-1:0] PER     = CNT_W'(CHOP_CYC);
  localparam logic [CNT_W-1:0] BLK_M1  = CNT_W'(BLANK_CYC - 1);

  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [CNT_W-1:0] blk_r, blk_nxt;
  logic             blk_on_r, blk_on_nxt;
  logic [CNT_W-1:0] blen_r, blen_nxt;
  logic [CNT_W-1:0] on_len;
  logic [CNT_W-1:0] off_len;

  assign on_len  = (cif.duty > MAX_ON) ? MAX_ON : cif.duty;
  assign off_len = PER - on_len;

  always_comb begin
    cnt_nxt    = cnt_r;
    blk_nxt    = blk_r;
    blk_on_nxt = blk_on_r;
    blen_nxt   = blen_r;
    if (cif.sync_p || cnt_r == PER_M1) begin
      cnt_nxt = '0;
    end else begin
      cnt_nxt = cnt_r + CNT_W'(1);
    end
    if (cif.sync_p) begin
      blk_on_nxt = 1'b1;
      blk_nxt    = '0;
    end else if (blk_on_r) begin
      if (blk_r == BLK_M1) begin
        blk_on_nxt = 1'b0;
      end else begin
        blk_nxt = blk_r + CNT_W'(1);
      end
    end
    // blank length seen by the width check; restarts with the pulse
    if (cif.sync_p) begin
      blen_nxt = '0;
    end else if (blk_on_r) begin
      blen_nxt = blen_r + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      cnt_r    <= '0;
      blk_r    <= '0;
      blk_on_r <= 1'b0;
      blen_r   <= '0;
    end else begin
      cnt_r    <= cnt_nxt;
      blk_r    <= blk_nxt;
      blk_on_r <= blk_on_nxt;
      blen_r   <= blen_nxt;
    end
  end

  // off time first, then on portion
  assign cif.chop_on    = (cnt_r >= off_len);
  // window opens at end of off time
  assign cif.on_del_win = cif.chop_on && (cnt_r < off_len + WIN_LEN);
  assign cif.blank      = blk_on_r;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  a_off_min_len: assert property (off_len >= CNT_W'(MIN_OFF_CYC))
    else $error("off time shorter than minimum");
  a_off_edge_fit: assert property (off_len > CNT_W'(EDGE_CYC))
    else $error("off time does not cover fall and rise");
  a_blank_width: assert property ($fell(cif.blank) |-> blen_r == CNT_W'(BLANK_CYC))
    else $error("blank pulse width wrong");
  // a duty write may move the on edge anywhere after the minimum off time
  a_win_start: assert property ($rose(cif.chop_on) && $stable(cif.duty)
      |-> cif.on_del_win)
    else $error("on delay window not at end of off time");

endmodule // spcbp_chop

//--- spcbp_top.sv
// spcbp_top: spindle commutation sequencer and back EMF phase detection
// Summary of operation
// - start bit selects start or run-phased detection
// - start mode outputs xor of three comparators
// - detection keeps running in direct pattern drive
// - tripolar pattern marks detection as invalid
// - run mode uses run-phased detection after the first phase A fall
// - sample/hold holds during chop off time
// - phase flag updates on blank comparator rise
// - flag takes on-delay window value at edge
// - preload reaches outputs at commutation clock rise
// - all-ones preload enables state counter
// - next commutation edge then outputs state 0
// - every chop cycle has minimum off time
// - minimum off time exceeds fall plus rise
// - off one-shot syncs chop to commutation clock
// - on-delay window 22 percent after off time
// - chop blank pulse nominally 25 us
// - run mode alternates high and low side chop
// - first run crossing is phase A negative
// assumes pins from the motor side and the controller are asynchronous to clk_i
`timescale 1ns/1ns
module spcbp_top
  import spcbp_pkg::*;
(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [DATA_W-1:0] reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [DATA_W-1:0] reg_rdata_o,
  // controller link
  input  wire logic              commutation_clock_i,
  output logic                   bemf_detect_out_o,
  // motor comparators
  input  wire logic [2:0]        phase_cmp_i,
  input  wire logic              blank_cmp_i,
  // drivers
  output logic      [PAT_W-1:0]  phase_drive_o,
  output logic                   chop_on_o,
  output logic                   chop_hi_side_o,
  output logic                   sh_hold_o,
  output logic                   chop_blank_o,
  output logic                   bemf_valid_o
);

  spcbp_chop_if cif ();

  // synchronisers: stage one feeds stage two only
  logic [4:0] sy1_r, sy2_r, sy3_r;
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      sy1_r <= 5'h00;
      sy2_r <= 5'h00;
      sy3_r <= 5'h00;
    end else begin
      sy1_r <= {blank_cmp_i, phase_cmp_i, commutation_clock_i};
      sy2_r <= sy1_r;
      sy3_r <= sy2_r;
    end
  end

  logic       cclk_rise;
  logic       blank_rise;
  logic       cmp_a_fall;
  logic [2:0] cmp_s;
  assign cclk_rise  = sy2_r[0] && !sy3_r[0];
  assign blank_rise = sy2_r[4] && !sy3_r[4];
  assign cmp_a_fall = !sy2_r[1] && sy3_r[1];
  assign cmp_s      = sy2_r[3:1];

  function automatic logic [PAT_W-1:0] spcbp_pattern(input spcbp_state_t s);
    unique case (s)
      SPCBP_S0: spcbp_pattern = 6'h09;
      SPCBP_S1: spcbp_pattern = 6'h18;
      SPCBP_S2: spcbp_pattern = 6'h12;
      SPCBP_S3: spcbp_pattern = 6'h06;
      SPCBP_S4: spcbp_pattern = 6'h24;
      SPCBP_S5: spcbp_pattern = 6'h21;
      default:  spcbp_pattern = PAT_RST;
    endcase
  endfunction

  function automatic spcbp_state_t spcbp_step(input spcbp_state_t s);
    unique case (s)
      SPCBP_S0: spcbp_step = SPCBP_S1;
      SPCBP_S1: spcbp_step = SPCBP_S2;
      SPCBP_S2: spcbp_step = SPCBP_S3;
      SPCBP_S3: spcbp_step = SPCBP_S4;
      SPCBP_S4: spcbp_step = SPCBP_S5;
      SPCBP_S5: spcbp_step = SPCBP_S0;
      default:  spcbp_step = SPCBP_S0;
    endcase
  endfunction

  // comparator of the undriven phase; zero when none floats
  function automatic logic spcbp_float_cmp(input logic [PAT_W-1:0] p, input logic [2:0] c);
    logic r;
    r = 1'b0;
    if (p[5:4] == 2'b00) begin
      r = c[0];
    end else if (p[3:2] == 2'b00) begin
      r = c[1];
    end else if (p[1:0] == 2'b00) begin
      r = c[2];
    end
    return r;
  endfunction

  // registers
  logic             start_r, start_nxt;
  logic [PAT_W-1:0] pend_r, pend_nxt;
  logic [CNT_W-1:0] duty_r, duty_nxt;
  logic             seq_en_r, seq_en_nxt;
  logic             seq_first_r, seq_first_nxt;
  spcbp_state_t     state_r, state_nxt;
  logic [PAT_W-1:0] drive_r, drive_nxt;
  logic             phdet_r, phdet_nxt;
  logic             sh_r, sh_nxt;
  logic             bemf_r, bemf_nxt;
  logic             side_r, side_nxt;
  logic             first_run_r, first_run_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic             tripolar;

  assign tripolar = (drive_r[5:4] != 2'b00) && (drive_r[3:2] != 2'b00)
                 && (drive_r[1:0] != 2'b00);

  always_comb begin
    start_nxt     = start_r;
    pend_nxt      = pend_r;
    duty_nxt      = duty_r;
    seq_en_nxt    = seq_en_r;
    seq_first_nxt = seq_first_r;
    state_nxt     = state_r;
    drive_nxt     = drive_r;
    phdet_nxt     = phdet_r;
    sh_nxt        = sh_r;
    bemf_nxt      = bemf_r;
    side_nxt      = side_r;
    first_run_nxt = first_run_r;
    rdata_nxt     = '0;
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        REG_CTRL: begin
          start_nxt = reg_wdata_i[CTRL_START_BIT];
          if (start_r && !reg_wdata_i[CTRL_START_BIT]) begin
            first_run_nxt = 1'b1;
          end
        end
        REG_PRELOAD: begin
          pend_nxt = reg_wdata_i[PAT_W-1:0];
          if (reg_wdata_i[PAT_W-1:0] == PAT_ALL_ONES) begin
            seq_en_nxt    = 1'b1;
            seq_first_nxt = 1'b1;
          end else begin
            seq_en_nxt    = 1'b0;
            seq_first_nxt = 1'b0;
          end
        end
        REG_DUTY: duty_nxt = reg_wdata_i[CNT_W-1:0];
        default: ;
      endcase
    end
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        REG_CTRL:    rdata_nxt[CTRL_START_BIT] = start_r;
        REG_PRELOAD: rdata_nxt[PAT_W-1:0] = pend_r;
        REG_DUTY:    rdata_nxt[CNT_W-1:0] = duty_r;
        REG_STATUS: begin
          rdata_nxt[ST_PHDET_BIT]                 = phdet_r;
          rdata_nxt[ST_SEQEN_BIT]                 = seq_en_r;
          rdata_nxt[ST_STATE_LSB+2:ST_STATE_LSB]  = state_r;
          rdata_nxt[ST_BEMF_BIT]                  = bemf_r;
          rdata_nxt[ST_TRIPOL_BIT]                = tripolar;
          rdata_nxt[ST_SIDE_BIT]                  = side_r;
        end
        default: rdata_nxt = '0;
      endcase
    end
    // drive changes only on commutation rise
    if (cclk_rise) begin
      if (seq_en_r) begin
        // first edge after enable gives state 0
        if (seq_first_r) begin
          state_nxt = SPCBP_S0;
        end else begin
          state_nxt = spcbp_step(state_r);
        end
        seq_first_nxt = 1'b0;
        drive_nxt     = spcbp_pattern(state_nxt);
      end else begin
        drive_nxt = pend_r;
      end
      // alternate chop side in run mode
      if (!start_r) begin
        side_nxt = !side_r;
      end
    end
    sh_nxt = !cif.chop_on;
    if (blank_rise) begin
      phdet_nxt = cif.on_del_win;
    end
    if (start_r) begin
      bemf_nxt = ^cmp_s;
    end else if (first_run_r) begin
      // hold high until phase A falls
      bemf_nxt = 1'b1;
      if (cmp_a_fall) begin
        bemf_nxt      = 1'b0;
        first_run_nxt = 1'b0;
      end
    end else if (!sh_r) begin
      bemf_nxt = spcbp_float_cmp(drive_r, cmp_s);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      start_r     <= CTRL_START_RST;
      pend_r      <= PAT_RST;
      duty_r      <= DUTY_RST;
      seq_en_r    <= 1'b0;
      seq_first_r <= 1'b0;
      state_r     <= SPCBP_S0;
      drive_r     <= PAT_RST;
      phdet_r     <= 1'b0;
      sh_r        <= 1'b1;
      bemf_r      <= 1'b0;
      side_r      <= 1'b0;
      first_run_r <= 1'b0;
      rdata_r     <= '0;
    end else begin
      start_r     <= start_nxt;
      pend_r      <= pend_nxt;
      duty_r      <= duty_nxt;
      seq_en_r    <= seq_en_nxt;
      seq_first_r <= seq_first_nxt;
      state_r     <= state_nxt;
      drive_r     <= drive_nxt;
      phdet_r     <= phdet_nxt;
      sh_r        <= sh_nxt;
      bemf_r      <= bemf_nxt;
      side_r      <= side_nxt;
      first_run_r <= first_run_nxt;
      rdata_r     <= rdata_nxt;
    end
  end

  assign cif.sync_p = cclk_rise;
  assign cif.duty   = duty_r;

  spcbp_chop u_chop (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .cif     (cif.timer)
  );

  assign reg_rdata_o       = rdata_r;
  assign bemf_detect_out_o = bemf_r;
  assign phase_drive_o     = drive_r;
  assign chop_on_o         = cif.chop_on;
  assign chop_hi_side_o    = side_r;
  assign sh_hold_o         = sh_r;
  assign chop_blank_o      = cif.blank;
  // tripolar drive gives no valid detection
  assign bemf_valid_o      = !tripolar;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  a_drive_hold: assert property (!cclk_rise |=> $stable(drive_r))
    else $error("drive changed without commutation edge");
  a_seq_state0: assert property (seq_en_r && seq_first_r && cclk_rise
      |=> state_r == SPCBP_S0 && drive_r == 6'h09)
    else $error("first sequenced state is not state 0");
  a_seq_wrap: assert property (seq_en_r && !seq_first_r && cclk_rise && state_r == SPCBP_S5
      |=> state_r == SPCBP_S0)
    else $error("state counter did not wrap to 0");
  a_preload_en: assert property (reg_wr_i && reg_addr_i == REG_PRELOAD
      |=> seq_en_r == ($past(reg_wdata_i[PAT_W-1:0]) == PAT_ALL_ONES))
    else $error("sequencer enable does not follow preload");
  a_phdet_edge: assert property (!blank_rise |=> $stable(phdet_r))
    else $error("phase flag changed off the blank edge");
  a_phdet_val: assert property (blank_rise |=> phdet_r == $past(cif.on_del_win))
    else $error("phase flag does not match window");
  a_start_xor: assert property (start_r && $past(start_r)
      |-> bemf_r == $past(^cmp_s))
    else $error("start mode output is not comparator xor");
  a_hold_off: assert property (!cif.chop_on |=> sh_r)
    else $error("sample/hold not held during off time");
  a_side_flip: assert property (cclk_rise && !start_r |=> side_r != $past(side_r))
    else $error("chop side did not alternate");
  a_tripol_inv: assert property (bemf_valid_o
      == !((|drive_r[5:4]) && (|drive_r[3:2]) && (|drive_r[1:0])))
    else $error("detection valid during tripolar drive");

endmodule // spcbp_top

//--- spcbp_ctl_model.sv
// spcbp_ctl_model: controller side of the commutation link, one clock pulse per call
// assumes the caller waits for pulse() to return before asking for the next one
`timescale 1ns/1ns
module spcbp_ctl_model (
  // link pins
  output logic      commutation_clock_o,
  input  wire logic bemf_detect_out_i,
  // detect line as the controller sees it
  output logic      bemf_seen_o
);
  logic blanking;

  initial begin
    commutation_clock_o = 1'b0;
    bemf_seen_o         = 1'b0;
    blanking            = 1'b0;
  end

  always @(bemf_detect_out_i or blanking) begin
    if (!blanking) begin
      bemf_seen_o = bemf_detect_out_i;
    end
  end

  // one 800 ns link period; the clock stands low between pulses
  task automatic pulse();
    #37;
    blanking            = 1'b1;
    commutation_clock_o = 1'b1;
    #400;
    commutation_clock_o = 1'b0;
    #363;
    blanking            = 1'b0;
  endtask
endmodule // spcbp_ctl_model

//--- testbench.sv
// testbench: self-checking bench for spcbp_top with a controller model
// assumes 10 MHz core clock, link periods of 800 ns, reads checked by a queue monitor
`timescale 1ns/1ns
module testbench;
  import spcbp_pkg::*;
  logic              clk_i;
  logic              rst_b_i;
  logic [ADDR_W-1:0] reg_addr_i;
  logic [DATA_W-1:0] reg_wdata_i;
  logic              reg_wr_i;
  logic              reg_rd_i;
  logic [DATA_W-1:0] reg_rdata_o;
  logic              commutation_clock_i;
  logic              bemf_detect_out_o;
  logic [2:0]        phase_cmp_i;
  logic              blank_cmp_i;
  logic [PAT_W-1:0]  phase_drive_o;
  logic              chop_on_o;
  logic              chop_hi_side_o;
  logic              sh_hold_o;
  logic              chop_blank_o;
  logic              bemf_valid_o;
  logic              bemf_seen;
  logic              rd_d;
  logic [15:0]       exp_q[$];
  logic [15:0]       msk_q[$];
  int                num_errors = 0;
  int                check_count = 0;

  spcbp_top dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .commutation_clock_i(commutation_clock_i),
    .bemf_detect_out_o(bemf_detect_out_o), .phase_cmp_i(phase_cmp_i),
    .blank_cmp_i(blank_cmp_i), .phase_drive_o(phase_drive_o), .chop_on_o(chop_on_o),
    .chop_hi_side_o(chop_hi_side_o), .sh_hold_o(sh_hold_o), .chop_blank_o(chop_blank_o),
    .bemf_valid_o(bemf_valid_o));

  spcbp_ctl_model ctl_u (.commutation_clock_o(commutation_clock_i),
    .bemf_detect_out_i(bemf_detect_out_o), .bemf_seen_o(bemf_seen));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task automatic close_out();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    @(posedge clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask

  // expected read value is queued; the monitor below compares it
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
  endtask

  task automatic wait_drive(input logic [PAT_W-1:0] e);
    int i;
    for (i = 0; i < 20 && phase_drive_o !== e; i++) @(posedge clk_i);
    if (phase_drive_o !== e) begin
      num_errors++;
      $display("[ERR] %0t drive timeout got %h exp %h", $time, phase_drive_o, e);
      close_out();
    end
    check_count++;
  endtask

  always @(posedge clk_i) rd_d <= reg_rd_i;
  always @(negedge clk_i) begin
    if (rd_d === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk(16'h0001, 16'h0000, "unexpected read");
      end else begin
        chk(reg_rdata_o & msk_q.pop_front(), exp_q.pop_front(), "read data");
      end
    end
  end

  initial begin
    repeat (100000) @(posedge clk_i);
    num_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    close_out();
  end

  initial begin
    logic [PAT_W-1:0] seq_pat [6];
    spcbp_state_t     seq_st [6];
    logic [31:0]      r;
    int               i, hi, run, mn, sh_bad;
    logic             s, off_prev;
    seq_pat = '{6'h09, 6'h18, 6'h12, 6'h06, 6'h24, 6'h21};
    seq_st = '{SPCBP_S0, SPCBP_S1, SPCBP_S2, SPCBP_S3, SPCBP_S4, SPCBP_S5};
    rst_b_i = 1'b0;
    reg_addr_i = '0;
    reg_wdata_i = '0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    phase_cmp_i = 3'h0;
    blank_cmp_i = 1'b0;
    r = $urandom(50);
    cyc(16);
    rst_b_i <= 1'b1;
    rd(REG_CTRL, 16'h0001, 16'h0001);
    rd(REG_STATUS, 16'h00E3, 16'h0000);
    rd(4'h2, 16'hFFFF, 16'h0000);
    wr(REG_PRELOAD, 16'h0012);
    cyc(10);
    chk(phase_drive_o, PAT_RST, "preload leaked");
    ctl_u.pulse();
    wait_drive(6'h12);
    wr(REG_PRELOAD, 16'h0026);
    ctl_u.pulse();
    wait_drive(6'h26);
    chk(bemf_valid_o, 1'b0, "tripolar valid");
    for (i = 0; i < 8; i++) begin
      phase_cmp_i <= 3'($urandom);
      cyc(6);
      chk(bemf_detect_out_o, ^phase_cmp_i, "start xor");
      chk(bemf_seen, bemf_detect_out_o, "detect seen");
    end
    wr(REG_PRELOAD, 16'h0021);
    ctl_u.pulse();
    wait_drive(6'h21);
    chk(bemf_valid_o, 1'b1, "bipolar valid");
    wr(REG_PRELOAD, 16'h003F);
    rd(REG_STATUS, 16'h0002, 16'h0002);
    for (i = 0; i < 7; i++) begin
      ctl_u.pulse();
      wait_drive(seq_pat[i % 6]);
      rd(REG_STATUS, 16'h001E, 16'h0002 | (16'(seq_st[i % 6]) << ST_STATE_LSB));
    end
    wr(REG_PRELOAD, 16'h0018);
    rd(REG_STATUS, 16'h0002, 16'h0000);
    ctl_u.pulse();
    wait_drive(6'h18);
    wr(REG_DUTY, 16'(434 + $urandom % 78));
    cyc(300);
    hi = 0;
    run = -1000;
    mn = 999;
    sh_bad = 0;
    off_prev = 1'b0;
    fork
      ctl_u.pulse();
      repeat (400) begin
        @(negedge clk_i);
        if (chop_blank_o === 1'b1) hi++;
        if (off_prev && sh_hold_o !== 1'b1) sh_bad++;
        off_prev = (chop_on_o === 1'b0);
        if (off_prev) run++;
        else begin
          if (run > 0 && run < mn) mn = run;
          run = 0;
        end
      end
    join
    chk(16'(hi), 16'(BLANK_CYC), "blank width");
    chk(mn >= MIN_OFF_CYC && mn < 999, 1'b1, "min off time");
    chk(16'(sh_bad), 16'h0000, "hold in off time");
    cyc(200);
    ctl_u.pulse();
    cyc(40);
    blank_cmp_i <= 1'b1;
    cyc(10);
    blank_cmp_i <= 1'b0;
    rd(REG_STATUS, 16'h0001, 16'h0001);
    cyc(150);
    blank_cmp_i <= 1'b1;
    cyc(10);
    blank_cmp_i <= 1'b0;
    rd(REG_STATUS, 16'h0001, 16'h0000);
    phase_cmp_i <= 3'h1;
    cyc(5);
    wr(REG_CTRL, 16'h0000);
    rd(REG_CTRL, 16'h0001, 16'h0000);
    cyc(6);
    chk(bemf_detect_out_o, 1'b1, "run entry held");
    phase_cmp_i <= 3'h0;
    cyc(6);
    chk(bemf_detect_out_o, 1'b0, "phase a fall");
    phase_cmp_i <= 3'h1;
    cyc(500);
    chk(bemf_detect_out_o, 1'b0, "undriven phase only");
    for (i = 0; i < 2; i++) begin
      s = chop_hi_side_o;
      ctl_u.pulse();
      cyc(5);
      chk(chop_hi_side_o, !s, "chop side");
    end
    cyc(4);
    chk(16'(exp_q.size()), 16'h0000, "reads left");
    close_out();
  end
endmodule // testbench
